// ===== sxb_map.vh
// address map and fixed constants of the system crossbar
// assumes includers use these as 32-bit address compares
`ifndef SXB_MAP_VH
`define SXB_MAP_VH
`define SXB_BOOT_LO     32'h0000_0000
`define SXB_BOOT_HI     32'h0000_3FFF
`define SXB_OTP_LO      32'h1000_1800
`define SXB_OTP_HI      32'h1000_1BFF
`define SXB_FLASH_LO    32'h1004_0000
`define SXB_FLASH_HI    32'h1007_FFFF
`define SXB_SRAM_LO     32'h2000_0000
`define SXB_SRAM_HI     32'h2000_FFFF
`define SXB_SRAM_BANK_LSB 14
`define SXB_SRAM_OFS_MASK 32'h0000_3FFF
`define SXB_APB0_LO     32'h4000_0000
`define SXB_APB0_HI     32'h4000_43FF
`define SXB_APB1_LO     32'h4100_0000
`define SXB_APB1_HI     32'h4100_73FF
`define SXB_AHB_PERIPHERAL_PORT_LO     32'h4800_0000
`define SXB_AHB_PERIPHERAL_PORT_HI     32'h4880_03FF
`define SXB_APB2_LO     32'h6000_0000
`define SXB_APB2_HI     32'h6000_1BFF
`define SXB_PPB_LO      32'hE000_0000
`define SXB_PPB_HI      32'hE00F_FFFF
`define SXB_SRAM0_RSV_HI 32'h2000_0017
`define SXB_NSLV        10
`define SXB_S_FLASH     4'h0
`define SXB_S_SRAM0     4'h1
`define SXB_S_APB0      4'h5
`define SXB_S_APB1      4'h6
`define SXB_S_AHB_PERIPHERAL_PORT      4'h7
`define SXB_S_APB2      4'h8
`define SXB_S_DEF       4'h9
`define SXB_HRESP_ERR   1'b1
`define SXB_CLKEN_RST   1'b0
`endif

// ===== sxb_decode.v
// address decoder for one master port of the system crossbar
// assumes address is the AHB address phase value
`default_nettype none
`include "sxb_map.vh"
module sxb_decode #(
	parameter [2:0] MASTER = 3'd0
) (
	input  wire [31:0] addr,      // address phase address
	input  wire        bootSram,  // boot alias selects sram0
	output reg  [3:0]  slaveSel,  // selected slave index
	output reg  [31:0] slaveAddr, // address after boot alias
	output reg         privHit    // core private bus hit
);
	reg [3:0] raw;
	always @* begin
		slaveAddr = addr;
		privHit   = 1'b0;
		raw       = `SXB_S_DEF;
		if (addr <= `SXB_BOOT_HI) begin
			// alias only from the cpu; other masters see reserved space
			raw = bootSram ? `SXB_S_SRAM0 : `SXB_S_FLASH;
			slaveAddr = bootSram ? (`SXB_SRAM_LO | addr) : (`SXB_FLASH_LO | addr);
		end else if (addr >= `SXB_OTP_LO && addr <= `SXB_OTP_HI)
			raw = `SXB_S_FLASH;
		else if (addr >= `SXB_FLASH_LO && addr <= `SXB_FLASH_HI)
			raw = `SXB_S_FLASH;
		else if (addr >= `SXB_SRAM_LO && addr <= `SXB_SRAM_HI)
			raw = `SXB_S_SRAM0 + {2'b00, addr[`SXB_SRAM_BANK_LSB+1:`SXB_SRAM_BANK_LSB]};
		else if (addr >= `SXB_APB0_LO && addr <= `SXB_APB0_HI)
			raw = `SXB_S_APB0;
		else if (addr >= `SXB_APB1_LO && addr <= `SXB_APB1_HI)
			raw = `SXB_S_APB1;
		else if (addr >= `SXB_AHB_PERIPHERAL_PORT_LO && addr <= `SXB_AHB_PERIPHERAL_PORT_HI)
			raw = `SXB_S_AHB_PERIPHERAL_PORT;
		else if (addr >= `SXB_APB2_LO && addr <= `SXB_APB2_HI)
			raw = `SXB_S_APB2;
		else if (addr >= `SXB_PPB_LO && addr <= `SXB_PPB_HI)
			privHit = (MASTER == 3'd0);
		slaveSel = raw;
		case (MASTER)
			3'd0: slaveSel = privHit ? `SXB_S_DEF : raw;
			3'd1: if (!(raw == `SXB_S_APB1 || (raw >= `SXB_S_SRAM0 && raw <= 4'h4))
					|| addr <= `SXB_BOOT_HI) slaveSel = `SXB_S_DEF;
			default: if (!(raw == `SXB_S_APB2 || (raw >= `SXB_S_SRAM0 && raw <= 4'h4))
					|| addr <= `SXB_BOOT_HI) slaveSel = `SXB_S_DEF;
		endcase
	end
endmodule
`default_nettype wire

// ===== sxb_arbiter.v
// round robin arbiter for one slave port of the system crossbar
// assumes reqs are address phase requests, done is slave hready
`default_nettype none
module sxb_arbiter (
	input  wire       clk,     // system clock
	input  wire       rst,     // async reset, high
	input  wire [2:0] req,     // per master requests
	input  wire       done,    // current transfer completes
	output reg  [2:0] grant,   // one hot grant
	output wire       busy     // data phase in progress
);
	reg [2:0] last_q;
	reg [2:0] owner_q;
	reg [2:0] pick;
	assign busy = |owner_q;
	always @* begin
		pick = 3'b000;
		case (last_q)
			3'b001:  pick = req[1] ? 3'b010 : req[2] ? 3'b100 : req[0] ? 3'b001 : 3'b000;
			3'b010:  pick = req[2] ? 3'b100 : req[0] ? 3'b001 : req[1] ? 3'b010 : 3'b000;
			default: pick = req[0] ? 3'b001 : req[1] ? 3'b010 : req[2] ? 3'b100 : 3'b000;
		endcase
		// hold owner until its data phase ends
		grant = (busy && !done) ? 3'b000 : pick;
	end
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			last_q  <= 3'b100;
			owner_q <= 3'b000;
		end else begin
			if (!busy || done) begin
				owner_q <= pick;
				if (|pick) last_q <= pick;
			end
		end
	end
endmodule
`default_nettype wire

// ===== sxb_crossbar.v
// system crossbar: three ahb masters to nine slaves plus default error slave
// assumes ahb-lite masters, single clock, slaves answer with hready/hresp
// Functional notes
// - 32-bit multilayer ahb fabric
// - three masters, nine slave ports
// - round robin among contending masters
// - different slaves proceed concurrently
// - cpu port reaches every slave
// - dma reaches sram banks and apb1 only
// - radio reaches sram banks and apb2 only
// - apb0/apb1 bridges fully synchronous
// - narrow apb writes replicated to 32 bits
// - little endian byte order
// - boot window aliases flash or sram0
// - flash at 0x1004_0000..0x1007_FFFF
// - otp at 0x1000_1800..0x1000_1BFF
// - four 16k sram banks from 0x2000_0000
// - apb0 from 0x4000_0000
// - apb1 from 0x4100_0000 to 0x4100_73FF
// - ahb_peripheral_port from 0x4800_0000 to 0x4880_03FF
// - apb2 from 0x6000_0000 to 0x6000_1BFF
// - private bus region goes to core
// - peripheral clocks off after reset
// - remap 0 flash, 1 sram0
`default_nettype none
`include "sxb_map.vh"
module sxb_crossbar (
	input  wire        clk,         // system clock
	input  wire        rst,         // async reset, high
	input  wire        bootRemap,   // boot alias selection
	input  wire [95:0] mHaddr,      // master addresses, cpu dma radio
	input  wire [5:0]  mHtrans,     // master htrans
	input  wire [2:0]  mHwrite,     // master hwrite
	input  wire [8:0]  mHsize,      // master hsize
	input  wire [95:0] mHwdata,     // master write data
	output reg  [95:0] mHrdata,     // master read data
	output reg  [2:0]  mHready,     // master hready
	output reg  [2:0]  mHresp,      // master hresp
	output wire        privSel,     // cpu private bus select
	output reg  [8:0]  sHsel,       // slave selects
	output reg  [287:0] sHaddr,     // slave addresses
	output reg  [17:0] sHtrans,     // slave htrans
	output reg  [8:0]  sHwrite,     // slave hwrite
	output reg  [26:0] sHsize,      // slave hsize
	output reg  [287:0] sHwdata,    // slave write data
	input  wire [287:0] sHrdata,    // slave read data
	input  wire [8:0]  sHready,     // slave hreadyout
	input  wire [8:0]  sHresp,      // slave hresp
	output wire [8:0]  periphClkEn  // per slave clock enable after reset
);
	wire [11:0] sel;
	wire [95:0] dAddr;
	wire [2:0]  priv;
	reg  [2:0]  reqM [0:9];
	wire [29:0] grantAll;
	wire [9:0]  busyAll;
	reg  [3:0]  dSel_q [0:2];
	reg  [2:0]  dWrite_q;
	reg  [5:0]  dSize_q;
	reg  [2:0]  errPh_q;
	reg  [2:0]  errAct_q;
	reg  [9:0]  slvDone;
	reg  [3:0]  cur;
	reg  [31:0] wd;
	integer     m;
	integer     s;

	// clock enables only for memories after reset
	assign periphClkEn = {4'b0000, 4'b1111, 1'b1};
	assign privSel = priv[0];

	genvar g;
	generate
		for (g = 0; g < 3; g = g + 1) begin : gDec
			sxb_decode #(.MASTER(g)) uDec (
				.addr      (mHaddr[32*g+31:32*g]),
				.bootSram  (bootRemap),
				.slaveSel  (sel[4*g+3:4*g]),
				.slaveAddr (dAddr[32*g+31:32*g]),
				.privHit   (priv[g])
			);
		end
		for (g = 0; g < 10; g = g + 1) begin : gArb
			sxb_arbiter uArb (
				.clk   (clk),
				.rst   (rst),
				.req   (reqM[g]),
				.done  (slvDone[g]),
				.grant (grantAll[3*g+2:3*g]),
				.busy  (busyAll[g])
			);
		end
	endgenerate

	always @* begin
		for (s = 0; s < 10; s = s + 1) begin
			reqM[s] = 3'b000;
			for (m = 0; m < 3; m = m + 1)
				if (mHtrans[2*m+1] && sel[4*m+:4] == s[3:0])
					reqM[s][m] = 1'b1;
			slvDone[s] = (s < 9) ? sHready[s] : 1'b1;
		end
	end

	// address phase routing per slave
	always @* begin
		sHsel   = 9'h000;
		sHaddr  = 288'h0;
		sHtrans = 18'h0_0000;
		sHwrite = 9'h000;
		sHsize  = 27'h000_0000;
		for (s = 0; s < 9; s = s + 1)
			for (m = 0; m < 3; m = m + 1)
				if (grantAll[3*s+m]) begin
					sHsel[s]         = 1'b1;
					sHaddr[32*s+:32] = dAddr[32*m+:32];
					sHtrans[2*s+:2]  = mHtrans[2*m+:2];
					sHwrite[s]       = mHwrite[m];
					sHsize[3*s+:3]   = mHsize[3*m+:3];
				end
	end

	// data phase state per master
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			dSel_q[0] <= `SXB_S_DEF;
			dSel_q[1] <= `SXB_S_DEF;
			dSel_q[2] <= `SXB_S_DEF;
			dWrite_q  <= 3'b000;
			dSize_q   <= 6'h00;
			errPh_q   <= 3'b000;
			errAct_q  <= 3'b000;
		end else begin
			for (m = 0; m < 3; m = m + 1) begin
				if (mHready[m]) begin
					// taken when granted, else stalls next cycle
					if (mHtrans[2*m+1] && grantAll[3*sel[4*m+:4]+m]) begin
						dSel_q[m]      <= sel[4*m+:4];
						dWrite_q[m]    <= mHwrite[m];
						dSize_q[2*m+:2] <= mHsize[3*m+:2];
						// private region is served by the core, not an error
						errAct_q[m]    <= (sel[4*m+:4] == `SXB_S_DEF) && !priv[m];
					end else begin
						dSel_q[m]   <= `SXB_S_DEF;
						errAct_q[m] <= 1'b0;
					end
				end
				// second error cycle follows the stalled first one
				errPh_q[m] <= errAct_q[m] && !errPh_q[m];
			end
		end
	end

	// response mux; default slave issues two cycle error
	always @* begin
		mHrdata = 96'h0;
		mHready = 3'b111;
		mHresp  = 3'b000;
		cur     = 4'h0;
		wd      = 32'h0000_0000;
		for (m = 0; m < 3; m = m + 1) begin
			cur = dSel_q[m];
			if (cur == `SXB_S_DEF) begin
				if (errAct_q[m] && !errPh_q[m]) begin
					mHready[m] = 1'b0;
					mHresp[m]  = `SXB_HRESP_ERR;
				end else if (mHtrans[2*m+1] && !grantAll[3*sel[4*m+:4]+m]
					&& sel[4*m+:4] != `SXB_S_DEF)
					mHready[m] = 1'b0; // stalled behind another owner
			end else begin
				mHrdata[32*m+:32] = sHrdata[32*cur+:32];
				mHready[m]        = sHready[cur];
				mHresp[m]         = sHresp[cur];
			end
		end
		for (m = 0; m < 3; m = m + 1)
			if (errPh_q[m]) begin
				mHresp[m]  = `SXB_HRESP_ERR;
				mHready[m] = 1'b1;
			end
	end

	// write data mux with narrow replication for apb bridges
	always @* begin
		sHwdata = 288'h0;
		for (m = 0; m < 3; m = m + 1) begin
			wd = mHwdata[32*m+:32];
			if (dSel_q[m] == `SXB_S_APB0 || dSel_q[m] == `SXB_S_APB1
				|| dSel_q[m] == `SXB_S_APB2) begin
				// lanes of a narrow write are ORed together and copied to all lanes
				if (dSize_q[2*m+:2] == 2'b00)
					wd = {4{wd[7:0] | wd[15:8] | wd[23:16] | wd[31:24]}};
				else if (dSize_q[2*m+:2] == 2'b01)
					wd = {2{wd[15:0] | wd[31:16]}};
			end
			if (dSel_q[m] != `SXB_S_DEF)
				sHwdata[32*dSel_q[m]+:32] = wd;
		end
	end
endmodule
`default_nettype wire

// ===== sxb_crossbar_assertions.sv
// port checker for the system crossbar, bound to its top module
// assumes one clock domain and the async high reset of the design
`default_nettype none
module sxb_crossbar_checker (
	input wire logic         clk,         // system clock
	input wire logic         rst,         // async reset, high
	input wire logic         bootRemap,   // boot alias selection
	input wire logic [95:0]  mHaddr,      // master addresses
	input wire logic [5:0]   mHtrans,     // master htrans
	input wire logic [2:0]   mHwrite,     // master hwrite
	input wire logic [8:0]   mHsize,      // master hsize
	input wire logic [8:0]   sHwrite,     // slave hwrite
	input wire logic [26:0]  sHsize,      // slave hsize
	input wire logic [2:0]   mHready,     // master hready
	input wire logic [2:0]   mHresp,      // master hresp
	input wire logic         privSel,     // private bus select
	input wire logic [8:0]   sHsel,       // slave selects
	input wire logic [287:0] sHaddr,      // slave addresses
	input wire logic [8:0]   periphClkEn  // clock enables
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	wire [31:0] cA = mHaddr[31:0];
	wire cpuOnly = mHtrans[1] && mHready[0] && mHtrans[5:2] == 4'h0;
	sequence errSeq(int m);
		!mHready[m] ##1 (mHready[m] && mHresp[m]);
	endsequence
	sequence cpuReq(lo, hi);
		cpuOnly && cA >= lo && cA <= hi;
	endsequence
	a_dma_unreach: assert property (mHtrans[3] && mHready[1] &&
		mHaddr[63:48] == 16'h1004 |=> errSeq(1)) else $error("dma reached flash");
	a_radio_unreach: assert property (mHtrans[5] && mHready[2] &&
		mHaddr[95:80] == 16'h4100 |=> errSeq(2)) else $error("radio reached apb1");
	a_unmapped_err: assert property (cpuReq(32'h3000_0000, 32'h3FFF_FFFF)
		|=> errSeq(0)) else $error("no error on hole");
	a_priv_route: assert property (cpuOnly && cA[31:20] == 12'hE00
		|-> privSel && sHsel == 9'h000) else $error("private bus misrouted");
	a_clk_gate: assert property (periphClkEn == 9'h01F)
		else $error("clock enables wrong");
	a_boot_flash: assert property (cpuReq(32'h0000_0000, 32'h0000_3FFF) && !bootRemap
		|-> sHsel == 9'h001 && sHaddr[31:0] == (32'h1004_0000 | cA)) else $error("boot alias");
	a_boot_sram: assert property (cpuReq(32'h0000_0000, 32'h0000_3FFF) && bootRemap
		|-> sHsel == 9'h002 && sHaddr[63:32] == (32'h2000_0000 | cA)) else $error("boot sram");
	a_sram_bank: assert property (cpuReq(32'h2000_0000, 32'h2000_FFFF)
		|-> sHsel == (9'h002 << cA[15:14])) else $error("sram bank select");
	a_flash_sel: assert property (cpuReq(32'h1004_0000, 32'h1007_FFFF)
		|-> sHsel == 9'h001) else $error("flash select");
	a_ctrl_route: assert property (cpuOnly && sHsel[6]
		|-> sHwrite[6] == mHwrite[0] && sHsize[20:18] == mHsize[2:0])
		else $error("control not routed");
endmodule
bind sxb_crossbar sxb_crossbar_checker u_sxb_crossbar_checker (.clk(clk), .rst(rst),
	.bootRemap(bootRemap), .mHaddr(mHaddr), .mHtrans(mHtrans), .mHready(mHready),
	.mHwrite(mHwrite), .mHsize(mHsize), .sHwrite(sHwrite), .sHsize(sHsize),
	.mHresp(mHresp), .privSel(privSel), .sHsel(sHsel), .sHaddr(sHaddr),
	.periphClkEn(periphClkEn));
`default_nettype wire

// ===== sxb_slave_model.sv
// nine ahb slaves facing the crossbar, data tagged with slave and address
// assumes one clock; slow adds one wait state to every data phase
`default_nettype none
module sxb_slave_model (
	input  wire logic         clk,     // system clock
	input  wire logic         rst,     // async reset, high
	input  wire logic         slow,    // one wait state per transfer
	input  wire logic [8:0]   sHsel,   // slave selects
	input  wire logic [287:0] sHaddr,  // slave addresses
	input  wire logic [17:0]  sHtrans, // slave htrans
	output var  logic [287:0] sHrdata, // read data
	output var  logic [8:0]   sHready, // hreadyout
	output var  logic [8:0]   sHresp   // always okay
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [8:0]  act_q, wt_q;
	logic [15:0] a_q [9];
	always_ff @(posedge clk or posedge rst) begin
		for (int i = 0; i < 9; i++) begin
			if (rst) begin
				act_q[i] <= 1'b0;
				wt_q[i] <= 1'b0;
			end else if (sHready[i]) begin
				act_q[i] <= sHsel[i] && sHtrans[2*i+1];
				wt_q[i] <= slow;
				a_q[i] <= sHaddr[32*i+:16];
			end else wt_q[i] <= 1'b0;
		end
	end
	// idle lanes carry inverted data so a stale value never matches
	always_comb begin
		for (int i = 0; i < 9; i++) begin
			sHready[i] = !(act_q[i] && wt_q[i]);
			sHresp[i] = 1'b0;
			sHrdata[32*i+:32] = {4'hD, 4'(i), 8'h00, a_q[i]} ^ {32{!act_q[i] || wt_q[i]}};
		end
	end
endmodule
`default_nettype wire

// ===== sxb_crossbar_test.sv
// self-checking bench: three ahb masters driven by tasks, slave model behind
// assumes inputs change at the falling edge, outputs sampled at the rising edge
`default_nettype none
`define CK(n,e,g) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; \
	$display("unexpected %s exp %h got %h", n, e, g); end end
module sxb_crossbar_test;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = 0, rst = 1, bootRemap = 0, slow = 0;
	logic [95:0] mHaddr = '0, mHwdata = '0;
	logic [5:0] mHtrans = '0;
	logic [2:0] mHwrite = '0;
	logic [8:0] mHsize = '0;
	wire [95:0] mHrdata;
	wire [2:0] mHready, mHresp;
	wire privSel;
	wire [8:0] sHsel, sHwrite, sHready, sHresp, periphClkEn;
	wire [287:0] sHaddr, sHwdata, sHrdata;
	wire [17:0] sHtrans;
	wire [26:0] sHsize;
	int n_checks = 0, n_mismatch = 0;
	time doneT [3];
	logic [287:0] lastWd;
	logic [31:0] tA [20] = '{32'h1004_0000, 32'h1000_1800, 32'h2000_0018, 32'h2000_4000,
		32'h2000_8000, 32'h2000_C000, 32'h4000_003C, 32'h4100_73FC, 32'h4880_03FC,
		32'h6000_1BFC, 32'h3000_0000, 32'h1004_0000, 32'h2000_8004, 32'h4100_0000,
		32'h6000_0000, 32'h4800_0000, 32'h4100_0000, 32'h6000_0000, 32'h2000_C008, 32'h0};
	int tM [20] = '{0,0,0,0,0,0,0,0,0,0,0,1,1,1,1,1,2,2,2,2};
	int tS [20] = '{0,0,1,2,3,4,5,6,7,8,-1,-1,3,6,-1,-1,-1,8,4,-1};
	sxb_crossbar u_sxb_crossbar (.clk, .rst, .bootRemap, .mHaddr, .mHtrans, .mHwrite,
		.mHsize, .mHwdata, .mHrdata, .mHready, .mHresp, .privSel, .sHsel, .sHaddr,
		.sHtrans, .sHwrite, .sHsize, .sHwdata, .sHrdata, .sHready, .sHresp, .periphClkEn);
	sxb_slave_model u_sxb_slave_model (.clk, .rst, .slow, .sHsel, .sHaddr, .sHtrans,
		.sHrdata, .sHready, .sHresp);
	always #2.5 clk = ~clk;
	task print_verdict;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic waitRdy(int m);
		int k = 0;
		do begin @(posedge clk); k++; end while (mHready[m] !== 1'b1 && k < 40);
		if (k >= 40) begin
			n_mismatch++;
			$display("unexpected timeout master %0d exp 1 got %b", m, mHready[m]);
			print_verdict;
		end
	endtask
	// one single transfer; address held until taken, data held until done
	task automatic ahb(int m, logic [31:0] a, logic w, logic [2:0] sz, logic [31:0] wd,
		output logic [31:0] rd, output logic e);
		@(negedge clk);
		{mHaddr[m*32+:32], mHtrans[m*2+:2], mHwrite[m], mHsize[m*3+:3]} = {a, 2'b10, w, sz};
		waitRdy(m);
		@(negedge clk);
		{mHtrans[m*2+:2], mHwdata[m*32+:32]} = {2'b00, wd};
		waitRdy(m);
		{rd, e, lastWd, doneT[m]} = {mHrdata[m*32+:32], mHresp[m], sHwdata, $time};
	endtask
	task automatic rd(int m, logic [31:0] a, int s);
		logic [31:0] d;
		logic e;
		ahb(m, a, 1'b0, 3'd2, '0, d, e);
		if (s < 0) `CK("errResp", 1'b1, e)
		else `CK("rdata", {4'hD, 4'(s), 8'h00, a[15:0]}, d)
	endtask
	task t_map;
		for (int i = 0; i < 20; i++) rd(tM[i], tA[i], tS[i]);
	endtask
	task t_boot;
		rd(0, 32'h0000_0010, 0);
		@(negedge clk) bootRemap = 1;
		rd(0, 32'h0000_0010, 1);
		@(negedge clk) bootRemap = 0;
	endtask
	task t_priv;
		@(negedge clk) {mHaddr[31:0], mHtrans[1:0]} = {32'hE000_E010, 2'b10};
		@(posedge clk) `CK("privSel", 1'b1, privSel)
		@(negedge clk) mHtrans[1:0] = 2'b00;
		repeat (3) @(posedge clk);
	endtask
	task t_conc;
		fork rd(0, 32'h2000_0018, 1); rd(1, 32'h2000_4004, 2); join
		`CK("sameTime", doneT[0], doneT[1])
	endtask
	// slow slaves: the loser must wait out the winner's wait state
	task t_arb;
		slow = 1;
		fork rd(0, 32'h2000_8000, 3); rd(1, 32'h2000_8004, 3); join
		`CK("cpuFirst", 1'b1, doneT[0] < doneT[1])
		fork rd(1, 32'h2000_8008, 3); rd(2, 32'h2000_800C, 3); join
		`CK("radioFirst", 1'b1, doneT[2] < doneT[1])
		slow = 0;
	endtask
	task t_narrow;
		logic [31:0] d;
		logic e;
		ahb(0, 32'h4100_0001, 1'b1, 3'd0, 32'h0000_AB00, d, e);
		`CK("byteWr", 32'hABAB_ABAB, lastWd[223:192])
		ahb(0, 32'h4100_0002, 1'b1, 3'd1, 32'h1234_0000, d, e);
		`CK("halfWr", 32'h1234_1234, lastWd[223:192])
	endtask
	initial begin
		repeat (4) @(posedge clk);
		@(negedge clk) rst = 0;
		`CK("clkEn", 9'h01F, periphClkEn)
		t_map;
		t_boot;
		t_priv;
		t_conc;
		t_arb;
		t_narrow;
		print_verdict;
	end
endmodule
`default_nettype wire
